/* File: core/mids_pkg.sv */
// Shared constants, types and state codes for the memory and I/O decode block
package mids_pkg;

  localparam int MIDS_ADDR_W     = 16;
  localparam int MIDS_DATA_W     = 8;
  localparam int MIDS_BLOCKS     = 8;
  localparam int MIDS_IO_BASES   = 8;
  localparam int MIDS_ROM_ADDR_W = 15;
  localparam int MIDS_BLK_LSB    = 13;
  localparam int MIDS_SPI_BITS   = 8;

  // Window offsets, low five bits of the I/O address
  localparam logic [4:0] MIDS_OFS_UART2 = 5'h08;
  localparam logic [4:0] MIDS_OFS_SPI   = 5'h10;
  localparam logic [4:0] MIDS_OFS_CARD  = 5'h11;
  localparam logic [4:0] MIDS_OFS_PAR   = 5'h18;

  // Topmost base and the panel address carved out of it
  localparam logic [2:0] MIDS_TOP_BASE  = 3'h7;
  localparam logic [4:0] MIDS_PANEL_OFS = 5'h1f;

  localparam logic       MIDS_CARD_RST  = 1'h1;
  localparam logic [7:0] MIDS_PAR_RST   = 8'h00;
  localparam logic       MIDS_KILL_RST  = 1'h0;
  localparam logic [7:0] MIDS_RD_IDLE   = 8'h00;

  // Shifter timing
  localparam int MIDS_CLK_NS        = 5;
  localparam int MIDS_SPI_FREQ_KHZ  = 2000;
  localparam int MIDS_SPI_PERIOD_NS = 1000000 / MIDS_SPI_FREQ_KHZ;
  localparam int MIDS_SPI_HALF_CYC  = MIDS_SPI_PERIOD_NS / 2 / MIDS_CLK_NS;

  typedef enum logic {
    MIDS_KILL_CARD = 1'b0,
    MIDS_KILL_PAR  = 1'b1
  } mids_kill_src_t;

  typedef enum logic [1:0] {
    MIDS_SPI_IDLE = 2'b00,
    MIDS_SPI_LOW  = 2'b01,
    MIDS_SPI_HIGH = 2'b10
  } mids_spi_state_t;

  typedef struct packed {
    logic ram_cs;
    logic ram_we;
    logic rom_cs;
    logic ext_cs;
  } mids_mem_sel_t;

  typedef struct packed {
    logic uart1_cs;
    logic uart2_cs;
    logic ext_cs;
  } mids_io_sel_t;

  typedef struct packed {
    logic din_en;
    logic din_inbound;
    logic dout_en;
    logic dout_outbound;
  } mids_buf_ctl_t;

endpackage : mids_pkg

/* File: core/mids_spi_shifter.sv */
// Eight-bit SPI master shifter, mode 0, most significant bit first
`timescale 1ns/100ps
module mids_spi_shifter
  import mids_pkg::*;
#(
  parameter int HALF_CYC = MIDS_SPI_HALF_CYC
) (
  input  wire logic       i_clk_sys,  // System clock
  input  wire logic       i_rst,      // Async reset, high
  input  wire logic       i_start,    // Load and start, one cycle
  input  wire logic [7:0] i_tx,       // Byte to send
  input  wire logic       i_miso,     // Serial data in
  output logic            o_sclk,     // Serial clock
  output logic            o_mosi,     // Serial data out
  output logic            o_busy,     // Transfer running
  output logic [7:0]      o_shift     // Shift register contents
);

  if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_bad_half
    $error("mids_spi_shifter: HALF_CYC out of range");
  end

  mids_spi_state_t state_reg, state_next;
  logic [15:0]     div_reg, div_next;
  logic [2:0]      bit_reg, bit_next;
  logic [7:0]      shift_reg, shift_next;
  logic            sclk_reg, sclk_next;
  logic            mosi_reg, mosi_next;
  logic            half_done;

  assign half_done = (div_reg == 16'(HALF_CYC - 1));

  always_comb begin
    state_next = state_reg;
    div_next   = half_done ? 16'h0000 : div_reg + 16'h0001;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    sclk_next  = sclk_reg;
    mosi_next  = mosi_reg;
    case (state_reg)
      MIDS_SPI_IDLE: begin
        div_next = 16'h0000;
        if (i_start) begin
          shift_next = i_tx;
          mosi_next  = i_tx[7];
          bit_next   = 3'h0;
          state_next = MIDS_SPI_LOW;
        end
      end
      // RULE26 sample on rise
      MIDS_SPI_LOW: begin
        if (half_done) begin
          sclk_next  = 1'b1;
          shift_next = {shift_reg[6:0], i_miso};
          state_next = MIDS_SPI_HIGH;
        end
      end
      MIDS_SPI_HIGH: begin
        if (half_done) begin
          sclk_next = 1'b0;
          mosi_next = shift_reg[7];
          bit_next  = bit_reg + 3'h1;
          // RULE26 eight bits each
          state_next = (bit_reg == 3'(MIDS_SPI_BITS - 1)) ? MIDS_SPI_IDLE : MIDS_SPI_LOW;
        end
      end
      default: begin
        state_next = MIDS_SPI_IDLE;
        sclk_next  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= MIDS_SPI_IDLE;
      div_reg   <= 16'h0000;
      bit_reg   <= 3'h0;
      shift_reg <= 8'h00;
      sclk_reg  <= 1'b0;
      mosi_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      sclk_reg  <= sclk_next;
      mosi_reg  <= mosi_next;
    end
  end

  assign o_sclk  = sclk_reg;
  assign o_mosi  = mosi_reg;
  assign o_busy  = (state_reg != MIDS_SPI_IDLE);
  assign o_shift = shift_reg;

endmodule : mids_spi_shifter

/* File: core/mids_top.sv */
// Memory, I/O window, shadow ROM and bus steering decode for the board
// Contract
// RULE1: Each 8K block has own RAM enable.
// RULE2: ROM per block, 32K image mirrored upward.
// RULE3: Neither enabled goes external; RAM-only uses RAM.
// RULE4: ROM-only reads ROM, writes hidden RAM.
// RULE5: Both: shadow reads ROM, killed uses RAM.
// RULE6: Reset re-enables shadow ROM always.
// RULE7: Card-select mode kills on first select.
// RULE8: Parallel mode: output bit0 kills shadow.
// RULE9: Parallel output clears to zero on reset.
// RULE10: Card kill flop cleared only by reset.
// RULE11: One-hot base picks one of eight windows.
// RULE12: No base selected means no onboard I/O.
// RULE13: Addresses outside window go to backplane.
// RULE14: Top window excludes address 0xFF.
// RULE15: Offsets 0-7 first UART, 8-F second.
// RULE16: 0x10 write starts SPI, read returns data.
// RULE17: 0x11 latches bit0; zero selects card.
// RULE18: Reset sets card latch, clears kill flop.
// RULE19: 0x18 reads input, writes output port.
// RULE20: Decode taken from backplane side signals.
// RULE21: Slave mode holds local processor off.
// RULE22: Slave mode reverses data buffer directions.
// RULE23: Buffers steered by three configuration inputs.
// RULE24: Output strobe pulses on every port write.
// RULE25: SPI master near 2 MHz drives clock.
// RULE26: Eight bits, MSB first, one shift register.
`timescale 1ns/100ps
module mids_top
  import mids_pkg::*;
#(
  parameter int SPI_HALF_CYC = MIDS_SPI_HALF_CYC
) (
  input  wire logic                       i_clk_sys,              // System clock
  input  wire logic                       i_rst,                  // Async reset, high
  input  wire logic [MIDS_ADDR_W-1:0]     i_addr,                 // Backplane address
  input  wire logic [MIDS_DATA_W-1:0]     i_wdata,                // Backplane write data
  input  wire logic                       i_mem_rd,               // Memory read cycle
  input  wire logic                       i_mem_wr,               // Memory write, one cycle
  input  wire logic                       i_io_rd,                // I/O read cycle
  input  wire logic                       i_io_wr,                // I/O write, one cycle
  input  wire logic [MIDS_BLOCKS-1:0]     i_block_ram_enable,     // RAM enable per block
  input  wire logic [MIDS_BLOCKS-1:0]     i_block_rom_enable,     // ROM enable per block
  input  wire logic [MIDS_IO_BASES-1:0]   i_io_base_select,       // One-hot window base
  input  wire logic                       i_kill_source_select,   // 0 card, 1 parallel
  input  wire logic                       i_master_slave_select,  // 1 master, 0 slave
  input  wire logic                       i_panel_type_select,    // Front panel kind
  input  wire logic                       i_external_memory_select, // External memory
  input  wire logic                       i_spi_loopback_link,    // MOSI looped to MISO
  input  wire logic [MIDS_DATA_W-1:0]     i_parallel_in,          // Parallel input port
  input  wire logic                       i_spi_miso,             // SPI data in
  output mids_mem_sel_t                   o_mem_sel,              // Memory selects
  output logic [MIDS_ROM_ADDR_W-1:0]      o_rom_addr,             // Mirrored ROM address
  output mids_io_sel_t                    o_io_sel,               // I/O selects
  output logic [MIDS_DATA_W-1:0]          o_rdata,                // Onboard register data
  output logic                            o_rdata_valid,          // Register data valid
  output logic [MIDS_DATA_W-1:0]          o_parallel_out,         // Parallel output port
  output logic                            o_parallel_strobe,      // Output write pulse
  output logic                            o_card_select_n,        // Card select, low
  output logic                            o_shadow_active,        // Shadow ROM mapped
  output logic                            o_hold_req,             // Local hold request
  output mids_buf_ctl_t                   o_buf_ctl,              // Data buffer steering
  output logic                            o_spi_sclk,             // SPI clock
  output logic                            o_spi_mosi,             // SPI data out
  output logic                            o_spi_busy              // SPI transfer running
);

  if (SPI_HALF_CYC < 1 || SPI_HALF_CYC > 65535) begin : g_bad_half
    $error("mids_top: SPI_HALF_CYC out of range");
  end

  // Memory decode
  logic [2:0] blk;
  logic       blk_ram;
  logic       blk_rom;
  logic       shadow_on;
  logic       rom_read;
  logic       ram_read;
  logic       mem_write_onboard;

  // I/O decode
  logic [7:0] io_addr;
  logic [4:0] io_ofs;
  logic       base_onehot;
  logic       win_hit;
  logic       io_cycle;
  logic       hit_uart1;
  logic       hit_uart2;
  logic       hit_spi;
  logic       hit_card;
  logic       hit_par;

  // State
  mids_mem_sel_t              mem_sel_reg, mem_sel_next;
  logic [MIDS_ROM_ADDR_W-1:0] rom_addr_reg, rom_addr_next;
  mids_io_sel_t               io_sel_reg, io_sel_next;
  logic [7:0]                 rdata_reg, rdata_next;
  logic                       rvalid_reg, rvalid_next;
  logic [7:0]                 par_reg, par_next;
  logic                       strobe_reg, strobe_next;
  logic                       card_reg, card_next;
  logic                       kill_reg, kill_next;
  logic                       shadow_reg, shadow_next;
  logic                       hold_reg, hold_next;
  mids_buf_ctl_t              buf_reg, buf_next;

  // Shifter link
  logic       spi_start;
  logic       spi_miso_eff;
  logic       spi_mosi;
  logic       spi_sclk;
  logic       spi_busy;
  logic [7:0] spi_shift;

  // RULE20 backplane address
  assign blk     = i_addr[MIDS_ADDR_W-1:MIDS_BLK_LSB];
  assign io_addr = i_addr[7:0];
  assign io_ofs  = io_addr[4:0];

  // RULE1 per-block RAM
  assign blk_ram = i_block_ram_enable[blk];
  // RULE2 per-block ROM
  assign blk_rom = i_block_rom_enable[blk];

  // RULE8 parallel bit0 kill
  // RULE10 card kill flop
  assign shadow_on = (i_kill_source_select == MIDS_KILL_PAR) ? ~par_reg[0] : ~kill_reg;

  // RULE4 ROM-only reads ROM
  // RULE5 shadow reads ROM
  assign rom_read = blk_rom & (~blk_ram | shadow_on);
  // RULE3 RAM-only block
  assign ram_read = blk_ram & ~rom_read;
  // RULE4 hidden RAM written
  assign mem_write_onboard = blk_ram | blk_rom;

  // RULE11 one-hot base
  assign base_onehot = (i_io_base_select != 8'h00) &&
                       ((i_io_base_select & (i_io_base_select - 8'h01)) == 8'h00);
  // RULE12 no base, no onboard
  // RULE14 panel address excluded
  assign win_hit = base_onehot && i_io_base_select[io_addr[7:5]] &&
                   !((io_addr[7:5] == MIDS_TOP_BASE) && (io_ofs == MIDS_PANEL_OFS));

  assign io_cycle = i_io_rd | i_io_wr;
  // RULE15 UART selects
  assign hit_uart1 = win_hit && (io_ofs < MIDS_OFS_UART2);
  assign hit_uart2 = win_hit && (io_ofs >= MIDS_OFS_UART2) && (io_ofs < MIDS_OFS_SPI);
  assign hit_spi   = win_hit && (io_ofs == MIDS_OFS_SPI);
  assign hit_card  = win_hit && (io_ofs == MIDS_OFS_CARD);
  assign hit_par   = win_hit && (io_ofs == MIDS_OFS_PAR);

  // RULE16 write starts transfer
  assign spi_start    = i_io_wr & hit_spi;
  assign spi_miso_eff = i_spi_loopback_link ? spi_mosi : i_spi_miso;

  // Memory decode registered
  always_comb begin
    mem_sel_next = '0;
    rom_addr_next = i_addr[MIDS_ROM_ADDR_W-1:0];
    if (i_mem_rd) begin
      mem_sel_next.rom_cs = rom_read;
      mem_sel_next.ram_cs = ram_read;
      // RULE3 leave to backplane
      mem_sel_next.ext_cs = ~rom_read & ~ram_read;
    end else if (i_mem_wr) begin
      // RULE5 writes into RAM
      mem_sel_next.ram_cs = mem_write_onboard;
      mem_sel_next.ram_we = mem_write_onboard;
      mem_sel_next.ext_cs = ~mem_write_onboard;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mem_sel_reg  <= '0;
      rom_addr_reg <= '0;
    end else begin
      mem_sel_reg  <= mem_sel_next;
      rom_addr_reg <= rom_addr_next;
    end
  end

  // I/O decode and onboard registers
  always_comb begin
    io_sel_next = '0;
    rdata_next  = MIDS_RD_IDLE;
    rvalid_next = 1'b0;
    par_next    = par_reg;
    strobe_next = 1'b0;
    card_next   = card_reg;
    kill_next   = kill_reg;
    if (io_cycle) begin
      io_sel_next.uart1_cs = hit_uart1;
      io_sel_next.uart2_cs = hit_uart2;
      // RULE13 outside window external
      io_sel_next.ext_cs = ~win_hit;
    end
    if (i_io_rd && win_hit && !hit_uart1 && !hit_uart2) begin
      rvalid_next = 1'b1;
      // RULE16 read shift contents
      if (hit_spi) begin
        rdata_next = spi_shift;
      // RULE19 read parallel input
      end else if (hit_par) begin
        rdata_next = i_parallel_in;
      end
    end
    if (i_io_wr) begin
      // RULE17 latch bit0 only
      if (hit_card) begin
        card_next = i_wdata[0];
      end
      // RULE19 write parallel output
      // RULE24 strobe per write
      if (hit_par) begin
        par_next    = i_wdata;
        strobe_next = 1'b1;
      end
    end
    // RULE7 first select kills
    // RULE10 sticky until reset
    if ((i_kill_source_select == MIDS_KILL_CARD) && !card_next) begin
      kill_next = 1'b1;
    end
  end

  // RULE6 reset restores shadow
  // RULE9 parallel port cleared
  // RULE18 card latch set
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      io_sel_reg <= '0;
      rdata_reg  <= MIDS_RD_IDLE;
      rvalid_reg <= 1'b0;
      par_reg    <= MIDS_PAR_RST;
      strobe_reg <= 1'b0;
      card_reg   <= MIDS_CARD_RST;
      kill_reg   <= MIDS_KILL_RST;
    end else begin
      io_sel_reg <= io_sel_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      par_reg    <= par_next;
      strobe_reg <= strobe_next;
      card_reg   <= card_next;
      kill_reg   <= kill_next;
    end
  end

  // Mode and bus steering, recomputed every cycle from the straps, the kill state and the current bus cycle
  always_comb begin
    shadow_next = shadow_on;
    // RULE21 hold in slave mode
    hold_next = ~i_master_slave_select;
    buf_next  = '0;
    // RULE22 slave reverses direction
    buf_next.din_inbound   = i_master_slave_select;
    buf_next.dout_outbound = i_master_slave_select;
    // RULE23 three inputs steer
    if (i_master_slave_select) begin
      buf_next.dout_en = i_mem_wr | i_io_wr;
      buf_next.din_en  = (i_mem_rd & (~(rom_read | ram_read) | i_external_memory_select)) |
                         (i_io_rd & (~win_hit | i_panel_type_select));
    end else begin
      buf_next.din_en  = (i_mem_wr & mem_write_onboard) | (i_io_wr & win_hit);
      buf_next.dout_en = (i_mem_rd & (rom_read | ram_read) & ~i_external_memory_select) |
                         (i_io_rd & win_hit);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      shadow_reg <= 1'b1;
      hold_reg   <= 1'b0;
      buf_reg    <= '0;
    end else begin
      shadow_reg <= shadow_next;
      hold_reg   <= hold_next;
      buf_reg    <= buf_next;
    end
  end

  // RULE25 shifter near 2 MHz
  mids_spi_shifter #(
    .HALF_CYC (SPI_HALF_CYC)
  ) u_spi (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (spi_start),
    .i_tx      (i_wdata),
    .i_miso    (spi_miso_eff),
    .o_sclk    (spi_sclk),
    .o_mosi    (spi_mosi),
    .o_busy    (spi_busy),
    .o_shift   (spi_shift)
  );

  assign o_mem_sel         = mem_sel_reg;
  assign o_rom_addr        = rom_addr_reg;
  assign o_io_sel          = io_sel_reg;
  assign o_rdata           = rdata_reg;
  assign o_rdata_valid     = rvalid_reg;
  assign o_parallel_out    = par_reg;
  assign o_parallel_strobe = strobe_reg;
  assign o_card_select_n   = card_reg;
  assign o_shadow_active   = shadow_reg;
  assign o_hold_req        = hold_reg;
  assign o_buf_ctl         = buf_reg;
  assign o_spi_sclk        = spi_sclk;
  assign o_spi_mosi        = spi_mosi;
  assign o_spi_busy        = spi_busy;

endmodule : mids_top

/* File: sim/mids_bus_master.sv */
// Behavioural backplane bus master driving memory and I/O cycles
`timescale 1ns/100ps
module mids_bus_master
  import mids_pkg::*;
(
  input  wire logic              i_clk_sys,  // Clock
  output logic [MIDS_ADDR_W-1:0] o_addr,     // Address
  output logic [MIDS_DATA_W-1:0] o_wdata,    // Write data
  output logic [3:0]             o_cmd       // mem_rd, mem_wr, io_rd, io_wr
);
  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_cmd   = '0;
  end

  task automatic cycle(input logic [3:0] cmd, input logic [MIDS_ADDR_W-1:0] addr,
                       input logic [MIDS_DATA_W-1:0] data);
    @(posedge i_clk_sys);
    #1;
    o_addr  = addr;
    o_wdata = data;
    o_cmd   = cmd;
    @(posedge i_clk_sys);
    #1;
    // Released lines carry junk, never the old value
    o_cmd   = '0;
    o_addr  = ~addr;
    o_wdata = ~data;
  endtask : cycle
endmodule : mids_bus_master

/* File: sim/mids_top_assertions.sv */
// Concurrent checks on the decode block ports
`timescale 1ns/100ps
module mids_top_chk
  import mids_pkg::*;
#(
  parameter int SPI_HALF_CYC = MIDS_SPI_HALF_CYC
) (
  input wire logic                     i_clk_sys,             // Clock
  input wire logic                     i_rst,                 // Reset
  input wire logic [MIDS_ADDR_W-1:0]   i_addr,                // Address
  input wire logic [MIDS_DATA_W-1:0]   i_wdata,               // Write data
  input wire logic                     i_mem_rd,              // Memory read
  input wire logic                     i_mem_wr,              // Memory write
  input wire logic                     i_io_rd,               // I/O read
  input wire logic                     i_io_wr,               // I/O write
  input wire logic [MIDS_BLOCKS-1:0]   i_block_ram_enable,    // RAM blocks
  input wire logic [MIDS_BLOCKS-1:0]   i_block_rom_enable,    // ROM blocks
  input wire logic [MIDS_IO_BASES-1:0] i_io_base_select,      // Window base
  input wire logic                     i_kill_source_select,  // Kill source
  input wire logic                     i_master_slave_select, // Master mode
  input wire mids_mem_sel_t            o_mem_sel,             // Memory selects
  input wire logic [MIDS_ROM_ADDR_W-1:0] o_rom_addr,          // ROM address
  input wire mids_io_sel_t             o_io_sel,              // I/O selects
  input wire logic [MIDS_DATA_W-1:0]   o_parallel_out,        // Output port
  input wire logic                     o_parallel_strobe,     // Output strobe
  input wire logic                     o_shadow_active,       // Shadow mapped
  input wire logic                     o_hold_req,            // Hold request
  input wire mids_buf_ctl_t            o_buf_ctl,             // Buffer steering
  input wire logic                     o_spi_busy             // SPI running
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic [2:0] blk;
  logic       req;
  assign blk = i_addr[15:13];
  assign req = i_io_rd | i_io_wr;

  a_rom_mirror: assert property (i_mem_rd |=> o_rom_addr == $past(i_addr[14:0]))
    else $error("ROM address not mirrored");
  a_ext_block: assert property (i_mem_rd && !i_block_ram_enable[blk]
    && !i_block_rom_enable[blk] |=> o_mem_sel == 4'b0001)
    else $error("Unmapped block not sent to backplane");
  a_rom_only_read: assert property (i_mem_rd && i_block_rom_enable[blk]
    && !i_block_ram_enable[blk] |=> o_mem_sel.rom_cs && !o_mem_sel.ram_cs)
    else $error("ROM-only block read not from ROM");
  a_write_to_ram: assert property (i_mem_wr && !i_mem_rd && (i_block_ram_enable[blk]
    || i_block_rom_enable[blk]) |=> o_mem_sel.ram_we && !o_mem_sel.ext_cs)
    else $error("Onboard block write not to RAM");
  a_par_kill_follow: assert property ($past(i_kill_source_select)
    |-> o_shadow_active == !$past(o_parallel_out[0]))
    else $error("Shadow does not follow output bit 0");
  a_card_kill_sticky: assert property (!o_shadow_active && !i_kill_source_select
    && !$past(i_kill_source_select) |=> !o_shadow_active)
    else $error("Card kill released without reset");
  a_no_base_io: assert property (req && i_io_base_select == 8'h00
    |=> o_io_sel == 3'b001)
    else $error("I/O decoded with no base");
  a_panel_excluded: assert property (req && i_io_base_select == 8'h80
    && i_addr[7:0] == 8'hff |=> o_io_sel == 3'b001)
    else $error("Panel address decoded onboard");
  a_first_uart: assert property (req && $onehot(i_io_base_select)
    && i_io_base_select[i_addr[7:5]] && i_addr[4:3] == 2'b00
    |=> o_io_sel == 3'b100)
    else $error("First serial port not selected");
  a_spi_start: assert property ($rose(o_spi_busy)
    |-> $past(i_io_wr) && $past(i_addr[4:0]) == MIDS_OFS_SPI)
    else $error("SPI started without a write");
  a_strobe_write: assert property (o_parallel_strobe
    |-> $past(i_io_wr) && o_parallel_out == $past(i_wdata))
    else $error("Strobe without matching port write");
  a_slave_hold: assert property (!i_master_slave_select
    |=> o_hold_req && !o_buf_ctl.din_inbound)
    else $error("Slave mode does not hold or reverse");

  c_shadow_kill: cover property (o_shadow_active ##1 !o_shadow_active);
  c_spi_run: cover property ($fell(o_spi_busy));
  c_strobe: cover property (o_parallel_strobe);
endmodule : mids_top_chk

bind mids_top mids_top_chk #(.SPI_HALF_CYC(SPI_HALF_CYC)) u_chk (
  .i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_mem_rd, .i_mem_wr, .i_io_rd, .i_io_wr,
  .i_block_ram_enable, .i_block_rom_enable, .i_io_base_select, .i_kill_source_select,
  .i_master_slave_select, .o_mem_sel, .o_rom_addr, .o_io_sel, .o_parallel_out,
  .o_parallel_strobe, .o_shadow_active, .o_hold_req, .o_buf_ctl, .o_spi_busy
);

/* File: sim/mids_top_tb.sv */
// Self-checking bench for the memory and I/O decode block
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module mids_top_tb
  import mids_pkg::*;
;
  logic i_clk_sys, i_rst, i_mem_rd, i_mem_wr, i_io_rd, i_io_wr, i_spi_miso;
  logic i_kill_source_select, i_master_slave_select, i_panel_type_select;
  logic i_external_memory_select, i_spi_loopback_link;
  logic [15:0] i_addr;
  logic [7:0]  i_wdata, i_block_ram_enable, i_block_rom_enable, i_io_base_select;
  logic [7:0]  i_parallel_in, o_rdata, o_parallel_out;
  logic [14:0] o_rom_addr;
  logic [3:0]  cmd;
  logic o_rdata_valid, o_parallel_strobe, o_card_select_n, o_shadow_active, o_hold_req;
  logic o_spi_sclk, o_spi_mosi, o_spi_busy;
  mids_mem_sel_t o_mem_sel;
  mids_io_sel_t  o_io_sel;
  mids_buf_ctl_t o_buf_ctl;
  int n_mismatch = 0;
  int checked = 0;

  assign {i_mem_rd, i_mem_wr, i_io_rd, i_io_wr} = cmd;
  // Far end answers the inverse of what it hears
  assign i_spi_miso = ~o_spi_mosi;

  mids_bus_master bm (.i_clk_sys, .o_addr(i_addr), .o_wdata(i_wdata), .o_cmd(cmd));
  mids_top #(.SPI_HALF_CYC(2)) dut (.*);

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset;
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
  endtask : do_reset

  task automatic mem(input logic wr, input logic [15:0] a, input logic [3:0] exp);
    bm.cycle(wr ? 4'b0100 : 4'b1000, a, 8'h00);
    `CHK("mem_sel", exp, o_mem_sel)
  endtask : mem

  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    bm.cycle(wr ? 4'b0001 : 4'b0010, a, d);
  endtask : io

  task automatic t_mem;
    i_block_ram_enable = 8'h05;
    i_block_rom_enable = 8'h26;
    mem(0, 16'h0000, 4'b1000);
    mem(0, 16'h2000, 4'b0010);
    mem(0, 16'h4000, 4'b0010);
    mem(0, 16'h6000, 4'b0001);
    mem(1, 16'h2001, 4'b1100);
    mem(1, 16'h4001, 4'b1100);
    mem(1, 16'h6001, 4'b0001);
    mem(0, 16'ha345, 4'b0010);
    `CHK("rom_addr", 15'h2345, o_rom_addr)
  endtask : t_mem

  task automatic t_card_kill;
    i_kill_source_select = 1'b0;
    i_io_base_select = 8'h01;
    io(1, 16'h0011, 8'hfe);
    `CHK("card_n", 1'b0, o_card_select_n)
    mem(0, 16'h4000, 4'b1000);
    `CHK("shadow", 1'b0, o_shadow_active)
    io(1, 16'h0011, 8'h01);
    `CHK("card_n", 1'b1, o_card_select_n)
    mem(0, 16'h4000, 4'b1000);
    do_reset();
    `CHK("shadow", 1'b1, o_shadow_active)
    mem(0, 16'h4000, 4'b0010);
  endtask : t_card_kill

  task automatic t_par_kill;
    i_kill_source_select = 1'b1;
    i_parallel_in = 8'h5a;
    io(1, 16'h0018, 8'h81);
    `CHK("par_out", 8'h81, o_parallel_out)
    `CHK("strobe", 1'b1, o_parallel_strobe)
    mem(0, 16'h4000, 4'b1000);
    `CHK("strobe", 1'b0, o_parallel_strobe)
    io(1, 16'h0018, 8'h80);
    mem(0, 16'h4000, 4'b0010);
    io(0, 16'h0018, 8'h00);
    `CHK("par_in", 8'h5a, o_rdata)
    `CHK("rvalid", 1'b1, o_rdata_valid)
  endtask : t_par_kill

  task automatic t_window;
    logic [7:0] b;
    for (int n = 0; n < 8; n++) begin
      i_io_base_select = 8'h01 << n;
      b = 8'(n * 32);
      io(0, {8'h00, b + 8'h07}, 8'h00);
      `CHK("uart1", 3'b100, o_io_sel)
      io(0, {8'h00, b + 8'h08}, 8'h00);
      `CHK("uart2", 3'b010, o_io_sel)
      io(0, {8'h00, b + 8'h20}, 8'h00);
      `CHK("outside", 3'b001, o_io_sel)
    end
    io(0, 16'h00ff, 8'h00);
    `CHK("panel", 3'b001, o_io_sel)
    io(0, 16'h00fe, 8'h00);
    `CHK("top_in", 3'b000, o_io_sel)
    i_io_base_select = 8'h00;
    io(0, 16'h0003, 8'h00);
    `CHK("no_base", 3'b001, o_io_sel)
  endtask : t_window

  task automatic t_spi(input logic loop, input logic [7:0] tx, input logic [7:0] exp);
    int   rises;
    logic prev;
    rises = 0;
    i_io_base_select = 8'h04;
    i_spi_loopback_link = loop;
    io(0, 16'h0050, 8'h00);
    `CHK("rd_no_start", 1'b0, o_spi_busy)
    io(1, 16'h0050, tx);
    `CHK("busy", 1'b1, o_spi_busy)
    `CHK("mosi_msb", tx[7], o_spi_mosi)
    prev = o_spi_sclk;
    for (int i = 0; i < 200 && o_spi_busy === 1'b1; i++) begin
      @(posedge i_clk_sys);
      #1;
      rises += (o_spi_sclk && !prev) ? 1 : 0;
      prev = o_spi_sclk;
    end
    `CHK("sclk_rises", 8, rises)
    io(0, 16'h0050, 8'h00);
    `CHK("spi_rd", exp, o_rdata)
  endtask : t_spi

  task automatic t_steer;
    i_io_base_select = 8'h01;
    i_master_slave_select = 1'b0;
    mem(0, 16'h0000, 4'b1000);
    `CHK("hold", 1'b1, o_hold_req)
    `CHK("slave_rd", 4'b0010, o_buf_ctl)
    io(1, 16'h0011, 8'h01);
    `CHK("slave_wr", 4'b1000, o_buf_ctl)
    i_master_slave_select = 1'b1;
    io(0, 16'h0040, 8'h00);
    `CHK("hold", 1'b0, o_hold_req)
    `CHK("m_offboard", 4'b1101, o_buf_ctl)
    io(0, 16'h0003, 8'h00);
    `CHK("m_onboard", 4'b0101, o_buf_ctl)
    i_panel_type_select = 1'b1;
    io(0, 16'h0003, 8'h00);
    `CHK("m_panel", 4'b1101, o_buf_ctl)
    i_external_memory_select = 1'b1;
    mem(0, 16'h0000, 4'b1000);
    `CHK("m_extmem", 4'b1101, o_buf_ctl)
  endtask : t_steer

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    i_rst = 1'b1;
    {i_kill_source_select, i_panel_type_select, i_external_memory_select} = 3'b000;
    i_master_slave_select = 1'b1;
    i_spi_loopback_link = 1'b0;
    {i_block_ram_enable, i_block_rom_enable, i_io_base_select} = 24'h000000;
    i_parallel_in = 8'h00;
    do_reset();
    `CHK("par_out", 8'h00, o_parallel_out)
    `CHK("card_n", 1'b1, o_card_select_n)
    `CHK("shadow", 1'b1, o_shadow_active)
    t_mem();
    t_card_kill();
    t_par_kill();
    t_window();
    t_spi(1'b1, 8'ha5, 8'ha5);
    t_spi(1'b0, 8'h3c, 8'hc3);
    t_steer();
    finish_test();
  end
endmodule : mids_top_tb
